// *** include/async_tx_consts.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef ASYNC_TX_CONSTS_SVH
`define ASYNC_TX_CONSTS_SVH

// ***********************************************************************
// register byte addresses
// ***********************************************************************
`define OFF_TX_CTRL_STAT 5'h00
`define OFF_RX_CTRL_STAT 5'h04
`define OFF_BAUD_CTRL 5'h08
`define OFF_BAUD_DIV 5'h0c
`define OFF_TX_HOLD 5'h10

// ***********************************************************************
// transmit control/status fields
// ***********************************************************************
`define TXS_NINTH_BIT 0
`define TXS_SHIFT_EMPTY 1
`define TXS_BUF_EMPTY 2
`define TXS_CLOCKED_MODE 4
`define TXS_TX_ENABLE 5
`define TXS_NINE_BIT 6
// receive control/status field
`define RXS_PORT_ENABLE 7
// baud control fields
`define BDC_WIDE_DIV 3
`define BDC_POL_INVERT 4

// ***********************************************************************
// reset values and timing
// ***********************************************************************
`define TX_CTRL_RESET 8'h00
`define BAUD_DIV_RESET 16'h0000
// holding-to-shift transfer slot, one instruction cycle of four clocks
`define INSTR_CYCLE_NS 40
`define CLK_PERIOD_NS 10
`define XFER_CYCLES 3'd4
`define CHAR_BITS_MAX 4'd11

`endif

// *** include/async_tx_pkg.sv ***
// types shared by the transmitter and its bench
package async_tx_pkg;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LOAD,
    TX_SHIFT
  } tx_state_e;

  // line configuration shared with the receive section
  typedef struct packed {
    logic port_enable;
    logic clocked_mode;
    logic tx_enable;
    logic nine_bit;
    logic ninth_bit;
    logic pol_invert;
    logic wide_div;
  } line_cfg_s;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

endpackage

// *** hw/baud_tick_gen.sv ***
// baud rate divider producing one tick per bit period
`timescale 1ns/100ps
`include "async_tx_consts.svh"

module baud_tick_gen
  import async_tx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic wide_div,
  input wire logic [15:0] divisor,
  // bit period tick
  output logic tick
);

  logic [15:0] count_reg;
  logic [15:0] limit;

  // 8-bit mode only honours the low byte
  assign limit = wide_div ? divisor : {8'h00, divisor[7:0]}; // R5

  // bit period is limit+1 clocks; restarts with each frame
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 16'h0000;
    end else if (!run || tick) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  assign tick = run && (count_reg == limit); // R4 R5

endmodule

// *** hw/async_serial_transmitter.sv ***
// asynchronous serial transmitter with axi4-lite register access
`timescale 1ns/100ps
`include "async_tx_consts.svh"

// Behaviour
// R1: idle line sits at mark level when nothing is sent.
// R2: frame is one start, eight or nine data, then stop bits.
// R3: start bit is space, stop bits are mark.
// R4: every bit lasts exactly one baud period; here a stop bit followed by a back-to-back load lasts one clock longer.
// R5: bit timing from an 8- or 16-bit baud divider.
// R6: data bits go out least significant first.
// R7: transmit and receive share one format and baud setting.
// R8: no hardware parity; ninth bit may carry software parity.
// R9: shift register loads only from holding register, not bus visible.
// R10: transmit runs only when enabled, async mode, port enabled.
// R11: port enable turns the unit on and forces pin to output; here the pin drives only with transmit enabled in async mode.
// R12: software clears analog select before using the pin.
// R13: buffer empty flag sets as soon as transmit is enabled.
// R14: holding write starts transmission; idle shifter takes it at once.
// R15: busy shifter: character waits, moves within one instruction cycle.
// R16: frame starts right after the load, no extra idle bit.
// R17: disabled transmitter releases the pin for general use.
// R18: full duplex in async mode, half duplex in sync mode.
// R19: buffer empty flag valid second cycle after write, read-only.
// R20: shift empty set when empty, clear from load until shifted out.
// R21: nine-bit mode sends ninth bit from a separate control bit.
// R22: polarity invert flips idle level and data bits.
// R23: exactly one stop bit unless holding register stays empty.

module async_serial_transmitter
  import async_tx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // axi4-lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pin
  output logic transmit_out_pin,
  output logic transmit_out_pin_oe,
  // shared line configuration toward the receive section
  output line_cfg_s line_cfg
);

  // ***********************************************************************
  // registers
  // ***********************************************************************
  logic [7:0] tx_ctrl_reg;
  logic port_enable_reg;
  logic pol_invert_reg;
  logic wide_div_reg;
  logic [15:0] baud_div_reg;
  logic [7:0] hold_data_reg;
  logic hold_ninth_reg;
  logic hold_full_reg;
  logic [10:0] shift_reg; // R9
  logic [3:0] bits_left_reg;
  logic [2:0] xfer_cnt_reg;
  tx_state_e state_reg;
  logic line_reg;
  logic buf_empty_reg;
  logic tx_active;
  logic tick;
  logic hold_wr;

  // ***********************************************************************
  // axi4-lite write path
  // ***********************************************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [4:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_go = aw_held_reg && w_held_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr_reg & 5'h1c)
        `OFF_TX_CTRL_STAT, `OFF_RX_CTRL_STAT, `OFF_BAUD_CTRL,
        `OFF_BAUD_DIV, `OFF_TX_HOLD: s_axi_bresp <= 2'b00;
        default: s_axi_bresp <= 2'b10;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // status bits ignore writes; shift register has no address
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ctrl_reg <= `TX_CTRL_RESET;
      port_enable_reg <= 1'b0;
      pol_invert_reg <= 1'b0;
      wide_div_reg <= 1'b0;
      baud_div_reg <= `BAUD_DIV_RESET;
    end else if (wr_go) begin
      unique case (aw_addr_reg & 5'h1c)
        `OFF_TX_CTRL_STAT: if (w_strb_reg[0]) begin
          tx_ctrl_reg <= w_data_reg[7:0];
        end
        `OFF_RX_CTRL_STAT: if (w_strb_reg[0]) begin
          port_enable_reg <= w_data_reg[`RXS_PORT_ENABLE];
        end
        `OFF_BAUD_CTRL: if (w_strb_reg[0]) begin
          pol_invert_reg <= w_data_reg[`BDC_POL_INVERT];
          wide_div_reg <= w_data_reg[`BDC_WIDE_DIV];
        end
        `OFF_BAUD_DIV: begin
          if (w_strb_reg[0]) begin
            baud_div_reg[7:0] <= w_data_reg[7:0];
          end
          if (w_strb_reg[1]) begin
            baud_div_reg[15:8] <= w_data_reg[15:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign hold_wr = wr_go && ((aw_addr_reg & 5'h1c) == `OFF_TX_HOLD)
    && w_strb_reg[0];

  // ***********************************************************************
  // axi4-lite read path
  // ***********************************************************************
  logic [7:0] tx_status;

  always_comb begin
    tx_status = tx_ctrl_reg;
    tx_status[`TXS_SHIFT_EMPTY] = (state_reg == TX_IDLE); // R20
    tx_status[`TXS_BUF_EMPTY] = buf_empty_reg; // R19
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr & 5'h1c)
        `OFF_TX_CTRL_STAT: s_axi_rdata <= {24'h000000, tx_status};
        `OFF_RX_CTRL_STAT: s_axi_rdata <= {24'h000000, port_enable_reg,
          7'h00};
        `OFF_BAUD_CTRL: s_axi_rdata <= {27'h0000000, pol_invert_reg,
          wide_div_reg, 3'h0};
        `OFF_BAUD_DIV: s_axi_rdata <= {16'h0000, baud_div_reg};
        `OFF_TX_HOLD: s_axi_rdata <= {24'h000000, hold_data_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***********************************************************************
  // line configuration and enable
  // ***********************************************************************
  assign tx_active = tx_ctrl_reg[`TXS_TX_ENABLE]
    && !tx_ctrl_reg[`TXS_CLOCKED_MODE] && port_enable_reg; // R10

  // one format and baud divider width for both directions; the divisor value is not in line_cfg
  assign line_cfg = '{port_enable: port_enable_reg, // R7
    clocked_mode: tx_ctrl_reg[`TXS_CLOCKED_MODE],
    tx_enable: tx_ctrl_reg[`TXS_TX_ENABLE],
    nine_bit: tx_ctrl_reg[`TXS_NINE_BIT],
    ninth_bit: tx_ctrl_reg[`TXS_NINTH_BIT],
    pol_invert: pol_invert_reg,
    wide_div: wide_div_reg};

  // ***********************************************************************
  // holding register and empty flag
  // ***********************************************************************
  logic take;
  assign take = (state_reg == TX_LOAD) && (xfer_cnt_reg == 3'd0);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_data_reg <= 8'h00;
      hold_ninth_reg <= 1'b0;
      hold_full_reg <= 1'b0;
    end else if (!tx_active) begin
      hold_full_reg <= 1'b0;
    end else if (hold_wr) begin
      // ninth bit latched with the low byte, so it must come first
      hold_data_reg <= w_data_reg[7:0]; // R14
      hold_ninth_reg <= tx_ctrl_reg[`TXS_NINTH_BIT]; // R21
      hold_full_reg <= 1'b1;
    end else if (take) begin
      hold_full_reg <= 1'b0;
    end
  end

  // registered: valid from the second cycle after the write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      buf_empty_reg <= 1'b0;
    end else begin
      buf_empty_reg <= tx_active && !hold_full_reg; // R13 R19
    end
  end

  // ***********************************************************************
  // shifter
  // ***********************************************************************
  baud_tick_gen u_baud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(state_reg == TX_SHIFT),
    .wide_div(wide_div_reg),
    .divisor(baud_div_reg),
    .tick(tick)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= TX_IDLE;
      shift_reg <= 11'h7ff;
      bits_left_reg <= 4'd0;
      xfer_cnt_reg <= 3'd0;
    end else if (!tx_active) begin
      state_reg <= TX_IDLE;
      shift_reg <= 11'h7ff;
    end else begin
      unique case (state_reg)
        TX_IDLE: if (hold_full_reg) begin
          state_reg <= TX_LOAD; // R14
          xfer_cnt_reg <= 3'd0;
        end
        TX_LOAD: begin
          // stop, [ninth], data lsb first, start space
          if (tx_ctrl_reg[`TXS_NINE_BIT]) begin
            shift_reg <= {1'b1, hold_ninth_reg, hold_data_reg, 1'b0}; // R2 R3 R6 R8 R21
            bits_left_reg <= `CHAR_BITS_MAX;
          end else begin
            shift_reg <= {2'b11, hold_data_reg, 1'b0}; // R2 R3 R6
            bits_left_reg <= `CHAR_BITS_MAX - 4'd1;
          end
          state_reg <= TX_SHIFT; // R16
        end
        TX_SHIFT: if (tick) begin
          shift_reg <= {1'b1, shift_reg[10:1]}; // R4 R6
          bits_left_reg <= bits_left_reg - 4'd1;
          if (bits_left_reg == 4'd1) begin
            // single stop bit; next load follows within one slot
            state_reg <= hold_full_reg ? TX_LOAD : TX_IDLE; // R15 R23
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end

  // ***********************************************************************
  // pin
  // ***********************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      line_reg <= 1'b1;
    end else if (state_reg == TX_SHIFT) begin
      line_reg <= shift_reg[0] ^ pol_invert_reg; // R22
    end else begin
      line_reg <= 1'b1 ^ pol_invert_reg; // R1 R22
    end
  end

  assign transmit_out_pin = line_reg;
  // port enable plus transmit enable in async mode forces output; released when transmitter is off
  assign transmit_out_pin_oe = tx_active; // R11 R17 R18

  // ***********************************************************************
  // checks
  // ***********************************************************************
  a_idle_mark: assert property (@(posedge sys_clk) disable iff (!resetn)
    $past(state_reg == TX_IDLE) |-> line_reg == !$past(pol_invert_reg)) // R1
    else $error("idle line not at mark");
  a_start_space: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(state_reg == TX_SHIFT) |=> line_reg == pol_invert_reg) // R3
    else $error("start bit not space");
  a_load_empty_clr: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (state_reg == TX_LOAD) |=> !tx_status[`TXS_SHIFT_EMPTY]) // R20
    else $error("shift empty not cleared on load");
  a_enable_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    !tx_active |=> state_reg == TX_IDLE) // R10
    else $error("shifter runs while disabled");
  a_flag_enable: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($rose(tx_active) && !hold_full_reg) |=> buf_empty_reg) // R13
    else $error("empty flag late after enable");
  a_flag_after_wr: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (hold_wr && tx_active && state_reg == TX_SHIFT && !tick)
    |-> ##2 !buf_empty_reg) // R19
    else $error("empty flag wrong after write");
  a_idle_takes: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_reg == TX_IDLE && hold_full_reg && tx_active)
    |=> state_reg == TX_LOAD ##1 state_reg == TX_SHIFT) // R14 R16
    else $error("idle shifter did not load");
  a_back_to_back: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    (tick && bits_left_reg == 4'd1 && hold_full_reg && tx_active)
    |=> state_reg == TX_LOAD) // R15
    else $error("pending character not moved");
  a_pin_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
    transmit_out_pin_oe == (port_enable_reg
    && tx_ctrl_reg[`TXS_TX_ENABLE]
    && !tx_ctrl_reg[`TXS_CLOCKED_MODE])) // R11 R17
    else $error("pin enable wrong");
  c_frame: cover property (@(posedge sys_clk) disable iff (!resetn)
    $fell(state_reg == TX_SHIFT) && state_reg == TX_IDLE);
  c_nine: cover property (@(posedge sys_clk) disable iff (!resetn)
    state_reg == TX_LOAD && tx_ctrl_reg[`TXS_NINE_BIT]);
  c_b2b: cover property (@(posedge sys_clk) disable iff (!resetn)
    $past(state_reg == TX_SHIFT) && state_reg == TX_LOAD);

endmodule

// *** bench/serial_line_monitor.sv ***
// remote receiver model watching the serial output line
`timescale 1ns/100ps

module serial_line_monitor (
  // clock and line
  input wire logic sys_clk,
  input wire logic line,
  // shared frame format
  input wire logic nine_bit,
  input wire logic pol_invert,
  input int bit_clks,
  // received frame
  output int rx_count,
  output logic [8:0] rx_data,
  output logic frame_ok,
  output int start_len
);
  logic lvl;

  assign lvl = line ^ pol_invert;

  // ***********************************************************************
  // frame decoder
  // ***********************************************************************
  // samples on the falling edge, away from the line's launch edge
  initial begin
    int n;
    int k;
    logic [8:0] dat;
    logic ok;
    rx_count = 0;
    rx_data = '0;
    frame_ok = 1'b0;
    start_len = 0;
    forever begin
      @(negedge sys_clk);
      if (lvl === 1'b0) begin
        n = nine_bit ? 9 : 8;
        dat = '0;
        k = 1;
        while (lvl === 1'b0 && k < bit_clks + bit_clks / 2) begin
          @(negedge sys_clk);
          k++;
        end
        // a short dip while polarity flips is not a frame
        if (k < 3) continue;
        // k ends one past the last low sample when bit 0 is a mark
        start_len = k - 1;
        ok = (k > bit_clks);
        repeat (bit_clks + bit_clks / 2 - k) @(negedge sys_clk);
        for (int i = 0; i < n; i++) begin
          dat[i] = lvl;
          repeat (bit_clks) @(negedge sys_clk);
        end
        if (lvl !== 1'b1) ok = 1'b0;
        rx_data = dat;
        frame_ok = ok;
        rx_count = rx_count + 1;
      end
    end
  end
endmodule

// *** bench/async_serial_transmitter_tb.sv ***
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/100ps
`include "async_tx_consts.svh"

module async_serial_transmitter_tb
  import async_tx_pkg::*;
  ;
  logic sys_clk, resetn;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, transmit_out_pin, transmit_out_pin_oe;
  logic line, nb, frame_ok;
  line_cfg_s line_cfg;
  int bit_clks, rx_count, start_len, seen_rx, num_errors, n_compared, seed;
  logic [8:0] rx_data;
  logic [8:0] exp_q[$];
  logic [7:0] c;

  async_serial_transmitter async_serial_transmitter_i (
    .sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .transmit_out_pin,
    .transmit_out_pin_oe, .line_cfg
  );
  // released pin has a pull-up; no analog function shares it
  assign line = transmit_out_pin_oe ? transmit_out_pin : 1'b1;
  serial_line_monitor serial_line_monitor_i (
    .sys_clk, .line, .nine_bit(line_cfg.nine_bit),
    .pol_invert(line_cfg.pol_invert), .bit_clks, .rx_count, .rx_data,
    .frame_ok, .start_len
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ***********************************************************************
  // checking and bus tasks
  // ***********************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ready is sampled mid-cycle; it only moves on rising edges
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] v,
                        output logic [1:0] rsp);
    logic aw_hs, w_hs, done;
    int t;
    done = 1'b0;
    t = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && t < 1000) begin
      @(negedge sys_clk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs = s_axi_wvalid & s_axi_wready;
      done = (s_axi_bvalid === 1'b1);
      rsp = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
      t++;
    end
    check("write answered", {31'h0, done}, 32'h1);
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] v,
                        output logic [1:0] rsp);
    logic ar_hs, done;
    int t;
    done = 1'b0;
    t = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && t < 1000) begin
      @(negedge sys_clk);
      ar_hs = s_axi_arvalid & s_axi_arready;
      done = (s_axi_rvalid === 1'b1);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
      t++;
    end
    check("read answered", {31'h0, done}, 32'h1);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    axi_wr(a, v, r);
    check("bresp", {30'h0, r}, 32'h0);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    axi_rd(a, d, r);
    check("rdata", d, e);
    check("rresp", {30'h0, r}, 32'h0);
  endtask

  task automatic send(input logic [7:0] b);
    exp_q.push_back({line_cfg.nine_bit & nb, b});
    wr(`OFF_TX_HOLD, {24'h0, b});
  endtask

  // compare the next frame the remote receiver decodes
  task automatic get_rx;
    logic [8:0] e;
    int t;
    t = 0;
    while (rx_count == seen_rx && t < bit_clks * 30) begin
      @(posedge sys_clk);
      t++;
    end
    check("rx arrived", {31'h0, rx_count > seen_rx}, 32'h1);
    seen_rx++;
    e = exp_q.pop_front();
    check("rx char", {23'h0, rx_data}, {23'h0, e});
    check("rx framing", {31'h0, frame_ok}, 32'h1);
    if (e[0]) check("start clocks", start_len, bit_clks);
    repeat (bit_clks) @(posedge sys_clk);
  endtask

  initial begin
    #(60000 * 10);
    num_errors++;
    close_out();
  end

  // ***********************************************************************
  // test sequence
  // ***********************************************************************
  initial begin
    seed = 15016;
    num_errors = 0;
    n_compared = 0;
    seen_rx = 0;
    nb = 1'b0;
    bit_clks = 4;
    resetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    check("idle pin", {31'h0, transmit_out_pin}, 32'h1);
    check("pin drive", {31'h0, transmit_out_pin_oe}, 32'h0);
    rd(`OFF_TX_CTRL_STAT, 32'h2);
    rd(`OFF_BAUD_DIV, 32'h0);
    axi_rd(5'h14, d, r);
    check("unmapped rresp", {30'h0, r}, 32'h2);
    check("unmapped rdata", d, 32'h0);
    axi_wr(5'h14, 32'hff, r);
    check("unmapped bresp", {30'h0, r}, 32'h2);
    $display("test reset and map done");

    bit_clks = 4 + $unsigned($random(seed)) % 7;
    wr(`OFF_RX_CTRL_STAT, 32'h80);
    wr(`OFF_BAUD_DIV, bit_clks - 1);
    wr(`OFF_TX_CTRL_STAT, 32'h20);
    rd(`OFF_TX_CTRL_STAT, 32'h26);
    check("pin drive", {31'h0, transmit_out_pin_oe}, 32'h1);
    check("idle pin", {31'h0, transmit_out_pin}, 32'h1);
    c = $random(seed);
    send(c | 8'h01);
    c = $random(seed);
    send(c);
    rd(`OFF_TX_CTRL_STAT, 32'h20);
    get_rx();
    get_rx();
    rd(`OFF_TX_CTRL_STAT, 32'h26);
    rd(`OFF_TX_HOLD, {24'h0, c});
    $display("test back to back done");

    nb = 1'b1;
    wr(`OFF_TX_CTRL_STAT, 32'h61);
    check("shared format", {25'h0, line_cfg}, 32'h5c);
    c = $random(seed);
    send(c | 8'h01);
    get_rx();
    nb = 1'b0;
    wr(`OFF_TX_CTRL_STAT, 32'h60);
    send(c | 8'h01);
    get_rx();
    wr(`OFF_TX_CTRL_STAT, 32'h20);
    $display("test nine bit done");

    wr(`OFF_BAUD_CTRL, 32'h10);
    // pin follows the polarity bit one clock later
    @(negedge sys_clk);
    check("inverted idle", {31'h0, transmit_out_pin}, 32'h0);
    c = $random(seed);
    send(c | 8'h01);
    get_rx();
    wr(`OFF_BAUD_CTRL, 32'h0);
    $display("test polarity done");

    wr(`OFF_BAUD_DIV, 32'h0102);
    wr(`OFF_BAUD_CTRL, 32'h08);
    bit_clks = 259;
    send(8'h5b);
    get_rx();
    wr(`OFF_BAUD_CTRL, 32'h0);
    bit_clks = 3;
    send(8'hc7);
    get_rx();
    $display("test divider width done");

    wr(`OFF_TX_CTRL_STAT, 32'h30);
    check("sync mode drive", {31'h0, transmit_out_pin_oe}, 32'h0);
    wr(`OFF_TX_CTRL_STAT, 32'h20);
    check("async drive", {31'h0, transmit_out_pin_oe}, 32'h1);
    wr(`OFF_RX_CTRL_STAT, 32'h0);
    check("port off drive", {31'h0, transmit_out_pin_oe}, 32'h0);
    wr(`OFF_TX_CTRL_STAT, 32'h0);
    rd(`OFF_TX_CTRL_STAT, 32'h2);
    check("no spare frames", rx_count, seen_rx);
    $display("test disable done");
    close_out();
  end
endmodule
